// ---- shared/coord_bus_pkg.sv ----
// Purpose: shared constants and carriers for the coordination bus run/trigger block
// Assumes: single clock core_clk at 40 MHz
// Notes:   register map sits on a plain strobe port
package coord_bus_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] ctrl_addr      = 4'h0;
  localparam logic [3:0] start_addr_lo  = 4'h1;
  localparam logic [3:0] start_addr_hi  = 4'h2;
  localparam logic [3:0] route_addr     = 4'h3;
  localparam logic [3:0] command_addr   = 4'h4;
  localparam logic [3:0] status_addr    = 4'h5;
  localparam logic [3:0] irq_stat_addr  = 4'h6;
  localparam logic [3:0] irq_mask_addr  = 4'h7;

  // ==========================================================
  // field positions
  localparam int ctrl_enable_bit    = 0;
  localparam int ctrl_trace_bit     = 1;
  localparam int cmd_pulse_bit      = 0;
  localparam int cmd_enable_bit     = 1;
  localparam int cmd_disable_bit    = 2;
  localparam int route_in_lsb       = 0;
  localparam int route_out_lsb      = 2;
  localparam int route_and_bit      = 4;
  localparam int sel_a_bit          = 0;
  localparam int sel_b_bit          = 1;

  // ==========================================================
  // event bits of the interrupt status
  localparam int ev_run_bit         = 0;
  localparam int ev_trig_in_bit     = 1;
  localparam int ev_trig_out_bit    = 2;
  localparam int ev_width           = 3;

  // ==========================================================
  // reset values
  localparam logic [1:0]  route_sel_reset  = 2'h0;
  localparam logic [31:0] start_reset      = 32'h0000_0000;
  localparam logic [2:0]  ev_reset         = 3'h0;

  // ==========================================================
  // timing: run_request_n pulse driven for a fixed time
  localparam int  clk_freq_hz      = 40_000_000;
  localparam int  run_pulse_ns     = 200;
  localparam int  run_pulse_cycles = (run_pulse_ns * (clk_freq_hz / 1_000_000) + 999) / 1000;
  localparam logic [3:0] run_pulse_count = 4'(run_pulse_cycles);

  typedef struct packed {
    logic [1:0] inbound;   // which internal triggers the bus trigger drives
    logic [1:0] outbound;  // which internal triggers send the bus trigger
    logic       out_and;   // outbound needs both selected triggers
  } route_type;

  typedef struct packed {
    logic       run_pulse;   // one cycle: begin user execution
    logic [31:0] run_addr;   // where execution begins
    logic       trace_start; // one cycle: start analyzer trace
  } run_cmd_type;

endpackage

// ---- verilog/coord_bus_trigger.sv ----
// Purpose: run/break and trigger routing logic between emulator and coordination bus
// Assumes: bus inputs asynchronous, all others synchronous to core_clk
// Notes:   open-drain bus lines are split into in, out and enable
`timescale 1ns/1ps

// Functional notes
// - with interaction on, an run_request_n pulse starts user code at start address.
// - with interaction on, ready is false in monitor, true in user code.
// - writing the run start address also turns interaction on.
// - with interaction off, ignore run_request_n and ready; never drive ready.
// - interaction setting does not touch trigger exchange over the bus.
// - a software request pulses the run_request_n line for all emulators.
// - a separate setting decides if run_request_n also starts analyzer trace.
// - inbound selection picks internal triggers driven by the bus trigger.
// - outbound selection sends bus trigger when a selected trigger rises.
// - both selected: inbound drives both; outbound per AND/OR setting.
// - at power-up both routing selections are none.
module coord_bus_trigger
  import coord_bus_pkg::*;
(
  input  wire logic        core_clk,            // system clock, 40 MHz
  input  wire logic        rstn,                // async reset, active low
  input  wire logic [3:0]  reg_addr,            // register address
  input  wire logic [31:0] reg_wdata,           // register write data
  input  wire logic        reg_write,           // write strobe
  input  wire logic        reg_read,            // read strobe
  output logic      [31:0] reg_rdata,           // read data, cycle after strobe
  output logic             irq,                 // level interrupt
  input  wire logic        in_monitor,          // emulator runs in monitor
  input  wire logic        run_request_n_in,    // bus run_request_n line level
  output logic             run_request_n_out,   // run_request_n drive value (low)
  output logic             run_request_n_oe,    // run_request_n driven
  input  wire logic        ready_in,            // bus ready line level
  output logic             ready_out,           // ready drive value
  output logic             ready_oe,            // ready driven
  input  wire logic        bus_trigger_in,      // bus trigger line level
  output logic             bus_trigger_out,     // bus trigger drive value
  output logic             bus_trigger_oe,      // bus trigger driven
  input  wire logic        internal_trigger_a,  // internal trigger a
  input  wire logic        internal_trigger_b,  // internal trigger b
  output logic             drive_trigger_a,     // assert internal trigger a
  output logic             drive_trigger_b,     // assert internal trigger b
  output run_cmd_type      run_cmd              // run start towards the core
);

  // ==========================================================
  // state
  logic        enable, next_enable;
  logic        trace_on, next_trace_on;
  logic [31:0] start, next_start;
  route_type   route, next_route;
  logic [3:0]  pulse_cnt, next_pulse_cnt;
  logic [2:0]  ev_stat, next_ev_stat;
  logic [2:0]  ev_mask, next_ev_mask;
  logic [31:0] next_rdata;
  logic        next_irq;
  logic [1:0]  exec_sync, next_exec_sync;
  logic [1:0]  trig_sync, next_trig_sync;
  logic        exec_prev, next_exec_prev;
  logic        trig_prev, next_trig_prev;
  logic        ta_prev, next_ta_prev;
  logic        tb_prev, next_tb_prev;
  run_cmd_type next_run_cmd;
  logic        next_ready_out, next_ready_oe;
  logic        next_run_n_out, next_run_oe;
  logic        next_trig_out, next_trig_oe;
  logic        next_drive_a, next_drive_b;

  logic        exec_fall, trig_rise, ta_rise, tb_rise, send_trig;
  logic [2:0]  ev_now;

  function automatic logic hit(input logic [3:0] a);
    hit = reg_write && (reg_addr == a);
  endfunction

  // ==========================================================
  // edge detection and routing
  always_comb begin
    exec_fall = exec_prev && !exec_sync[1];
    trig_rise = !trig_prev && trig_sync[1];
    ta_rise   = !ta_prev && internal_trigger_a;
    tb_rise   = !tb_prev && internal_trigger_b;
    if (route.out_and && route.outbound == 2'b11) begin
      send_trig = internal_trigger_a && internal_trigger_b && (ta_rise || tb_rise);
    end else begin
      send_trig = (route.outbound[sel_a_bit] && ta_rise) ||
                  (route.outbound[sel_b_bit] && tb_rise);
    end
    ev_now = '0;
    ev_now[ev_run_bit]      = enable && exec_fall;
    ev_now[ev_trig_in_bit]  = trig_rise;
    ev_now[ev_trig_out_bit] = send_trig;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_exec_sync = {exec_sync[0], run_request_n_in};
    next_trig_sync = {trig_sync[0], bus_trigger_in};
    next_exec_prev = exec_sync[1];
    next_trig_prev = trig_sync[1];
    next_ta_prev   = internal_trigger_a;
    next_tb_prev   = internal_trigger_b;
    next_enable    = enable;
    next_trace_on  = trace_on;
    next_start     = start;
    next_route     = route;
    next_pulse_cnt = pulse_cnt;
    next_ev_mask   = ev_mask;
    if (hit(ctrl_addr)) begin
      next_enable   = reg_wdata[ctrl_enable_bit];
      next_trace_on = reg_wdata[ctrl_trace_bit];
    end
    if (hit(start_addr_lo)) begin
      next_start[15:0] = reg_wdata[15:0];
      next_enable      = 1'b1;
    end
    if (hit(start_addr_hi)) begin
      next_start[31:16] = reg_wdata[15:0];
      next_enable       = 1'b1;
    end
    if (hit(route_addr)) begin
      next_route.inbound  = reg_wdata[route_in_lsb +: 2];
      next_route.outbound = reg_wdata[route_out_lsb +: 2];
      next_route.out_and  = reg_wdata[route_and_bit];
    end
    if (hit(command_addr)) begin
      if (reg_wdata[cmd_enable_bit]) begin
        next_enable = 1'b1;
      end
      if (reg_wdata[cmd_disable_bit]) begin
        next_enable = 1'b0;
      end
      if (reg_wdata[cmd_pulse_bit]) begin
        next_pulse_cnt = run_pulse_count;
      end
    end else if (pulse_cnt != 4'h0) begin
      next_pulse_cnt = pulse_cnt - 4'h1;
    end
    if (hit(irq_mask_addr)) begin
      next_ev_mask = reg_wdata[ev_width-1:0];
    end
    // set beats write-one-to-clear
    next_ev_stat = ev_stat;
    if (hit(irq_stat_addr)) begin
      next_ev_stat = ev_stat & ~reg_wdata[ev_width-1:0];
    end
    next_ev_stat = next_ev_stat | ev_now;
    next_irq     = |(next_ev_stat & next_ev_mask);

    next_run_cmd.run_pulse   = enable && exec_fall;
    next_run_cmd.run_addr    = start;
    next_run_cmd.trace_start = enable && exec_fall && trace_on;
    next_ready_out = !in_monitor;
    next_ready_oe  = enable;
    // open drain: drive low while pulsing
    next_run_n_out = 1'b0;
    next_run_oe    = (next_pulse_cnt != 4'h0);
    next_trig_out  = 1'b1;
    next_trig_oe   = send_trig;
    next_drive_a   = trig_rise && route.inbound[sel_a_bit];
    next_drive_b   = trig_rise && route.inbound[sel_b_bit];

    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        ctrl_addr:     next_rdata = {30'h0, trace_on, enable};
        start_addr_lo: next_rdata = {16'h0, start[15:0]};
        start_addr_hi: next_rdata = {16'h0, start[31:16]};
        route_addr:    next_rdata = {27'h0, route.out_and, route.outbound, route.inbound};
        status_addr:   next_rdata = {28'h0, ready_in, trig_sync[1], exec_sync[1], in_monitor};
        irq_stat_addr: next_rdata = {29'h0, ev_stat};
        irq_mask_addr: next_rdata = {29'h0, ev_mask};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      exec_sync         <= 2'b11;
      trig_sync         <= 2'b00;
      exec_prev         <= 1'b1;
      trig_prev         <= 1'b0;
      ta_prev           <= 1'b0;
      tb_prev           <= 1'b0;
      enable            <= 1'b0;
      trace_on          <= 1'b0;
      start             <= start_reset;
      route.inbound     <= route_sel_reset;
      route.outbound    <= route_sel_reset;
      route.out_and     <= 1'b1;
      pulse_cnt         <= 4'h0;
      ev_stat           <= ev_reset;
      ev_mask           <= ev_reset;
      irq               <= 1'b0;
      reg_rdata         <= 32'h0000_0000;
      run_cmd           <= '0;
      ready_out         <= 1'b0;
      ready_oe          <= 1'b0;
      run_request_n_out <= 1'b0;
      run_request_n_oe  <= 1'b0;
      bus_trigger_out   <= 1'b1;
      bus_trigger_oe    <= 1'b0;
      drive_trigger_a   <= 1'b0;
      drive_trigger_b   <= 1'b0;
    end else begin
      exec_sync         <= next_exec_sync;
      trig_sync         <= next_trig_sync;
      exec_prev         <= next_exec_prev;
      trig_prev         <= next_trig_prev;
      ta_prev           <= next_ta_prev;
      tb_prev           <= next_tb_prev;
      enable            <= next_enable;
      trace_on          <= next_trace_on;
      start             <= next_start;
      route             <= next_route;
      pulse_cnt         <= next_pulse_cnt;
      ev_stat           <= next_ev_stat;
      ev_mask           <= next_ev_mask;
      irq               <= next_irq;
      reg_rdata         <= next_rdata;
      run_cmd           <= next_run_cmd;
      ready_out         <= next_ready_out;
      ready_oe          <= next_ready_oe;
      run_request_n_out <= next_run_n_out;
      run_request_n_oe  <= next_run_oe;
      bus_trigger_out   <= next_trig_out;
      bus_trigger_oe    <= next_trig_oe;
      drive_trigger_a   <= next_drive_a;
      drive_trigger_b   <= next_drive_b;
    end
  end

endmodule

// ---- tb/coord_bus_trigger_asserts.sv ----
// Purpose: port-level checks of the run/trigger block
// Assumes: one clock domain, async active-low reset
// Notes:   bound to coord_bus_trigger below
`timescale 1ns/1ps
module coord_bus_trigger_asserts
  import coord_bus_pkg::*;
(
  input wire logic        core_clk,           // clock
  input wire logic        rstn,               // reset, active low
  input wire logic        in_monitor,         // monitor level
  input wire logic        run_request_n_in,   // run_request_n line
  input wire logic        run_request_n_oe,   // run_request_n drive
  input wire logic        ready_out,          // ready value
  input wire logic        ready_oe,           // ready drive
  input wire logic        bus_trigger_in,     // bus trigger line
  input wire logic        bus_trigger_oe,     // bus trigger drive
  input wire logic        internal_trigger_a, // trigger a in
  input wire logic        internal_trigger_b, // trigger b in
  input wire logic        drive_trigger_a,    // trigger a out
  input wire logic        drive_trigger_b,    // trigger b out
  input wire run_cmd_type run_cmd             // run start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // checks
  property p_ready; ready_oe |-> ready_out == !$past(in_monitor); endproperty
  a_ready: assert property (p_ready) else $error("ready level wrong");
  property p_off; run_cmd.run_pulse |-> ready_oe; endproperty
  a_off: assert property (p_off) else $error("run while disabled");
  property p_run; $fell(run_request_n_in) && ready_oe |-> ##[2:6] run_cmd.run_pulse; endproperty
  a_run: assert property (p_run) else $error("run_request_n not followed by run");
  property p_exec; $rose(run_request_n_oe) |-> run_request_n_oe[*8] ##1 !run_request_n_oe;
  endproperty
  a_exec: assert property (p_exec) else $error("run_request_n pulse width wrong");
  property p_trace; run_cmd.trace_start |-> run_cmd.run_pulse; endproperty
  a_trace: assert property (p_trace) else $error("trace without run");
  property p_drv; drive_trigger_a || drive_trigger_b |->
    $past(bus_trigger_in, 3) ##1 !(drive_trigger_a || drive_trigger_b); endproperty
  a_drv: assert property (p_drv) else $error("inbound trigger wrong");
  property p_out; bus_trigger_oe |->
    ($past(internal_trigger_a) || $past(internal_trigger_b)) ##1 !bus_trigger_oe; endproperty
  a_out: assert property (p_out) else $error("outbound trigger wrong");
  property p_rst; $rose(rstn) |-> !(bus_trigger_oe || drive_trigger_a || drive_trigger_b);
  endproperty
  a_rst: assert property (p_rst) else $error("trigger active at reset");
endmodule

bind coord_bus_trigger coord_bus_trigger_asserts chk_u (.core_clk(core_clk), .rstn(rstn),
  .in_monitor(in_monitor), .run_request_n_in(run_request_n_in),
  .run_request_n_oe(run_request_n_oe), .ready_out(ready_out), .ready_oe(ready_oe),
  .bus_trigger_in(bus_trigger_in), .bus_trigger_oe(bus_trigger_oe),
  .internal_trigger_a(internal_trigger_a), .internal_trigger_b(internal_trigger_b),
  .drive_trigger_a(drive_trigger_a), .drive_trigger_b(drive_trigger_b), .run_cmd(run_cmd));

// ---- tb/coord_bus_partner.sv ----
// Purpose: another instrument sharing the coordination bus
// Assumes: fire requests come one cycle long
// Notes:   resolves the shared open-drain lines
`timescale 1ns/1ps
module coord_bus_partner (
  input  wire logic core_clk,    // clock
  input  wire logic rstn,        // reset, active low
  input  wire logic fire_exec,   // pulse run_request_n
  input  wire logic fire_trig,   // pulse trigger
  input  wire logic dut_exec_oe, // block pulls run_request_n
  input  wire logic dut_trig_oe, // block drives trigger
  input  wire logic dut_trig,    // block trigger value
  input  wire logic dut_rdy_oe,  // block drives ready
  input  wire logic dut_rdy,     // block ready value
  output logic      exec_line,   // run_request_n line
  output logic      trig_line,   // trigger line
  output logic      ready_line   // ready line
);
  logic [3:0] exec_cnt;
  logic [3:0] trig_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      exec_cnt <= 4'h0;
      trig_cnt <= 4'h0;
    end else begin
      exec_cnt <= fire_exec ? 4'h5 : exec_cnt - 4'(exec_cnt != 4'h0);
      trig_cnt <= fire_trig ? 4'h6 : trig_cnt - 4'(trig_cnt != 4'h0);
    end
  end
  // pull-up on run_request_n and ready, pull-down on trigger
  assign exec_line  = !(dut_exec_oe || exec_cnt != 4'h0);
  assign trig_line  = (trig_cnt != 4'h0) || (dut_trig_oe && dut_trig);
  assign ready_line = dut_rdy_oe ? dut_rdy : 1'b1;
endmodule

// ---- tb/coord_bus_trigger_test.sv ----
// Purpose: register-driven test of the run/trigger block
// Assumes: partner model resolves the bus lines
// Notes:   events are counted and compared after a settle time
`timescale 1ns/1ps
module coord_bus_trigger_test;
  import coord_bus_pkg::*;
  logic core_clk = 0, rstn = 0, reg_write = 0, reg_read = 0, in_monitor = 0;
  logic fire_exec = 0, fire_trig = 0, trig_a = 0, trig_b = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, got_addr;
  logic irq, ex_out, ex_oe, ex_ln, rd_out, rd_oe, rd_ln, tg_out, tg_oe, tg_ln, drv_a, drv_b;
  run_cmd_type run_cmd;
  int miscompares = 0, checks = 0, n_run, n_tr, n_a, n_b, n_out, n_oe;
  always #12.5 core_clk = ~core_clk;
  coord_bus_trigger dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .irq(irq), .in_monitor(in_monitor), .run_request_n_in(ex_ln), .run_request_n_out(ex_out),
    .run_request_n_oe(ex_oe), .ready_in(rd_ln), .ready_out(rd_out), .ready_oe(rd_oe),
    .bus_trigger_in(tg_ln), .bus_trigger_out(tg_out), .bus_trigger_oe(tg_oe),
    .internal_trigger_a(trig_a), .internal_trigger_b(trig_b), .drive_trigger_a(drv_a),
    .drive_trigger_b(drv_b), .run_cmd(run_cmd));
  coord_bus_partner far_u (.core_clk(core_clk), .rstn(rstn), .fire_exec(fire_exec),
    .fire_trig(fire_trig), .dut_exec_oe(ex_oe), .dut_trig_oe(tg_oe), .dut_trig(tg_out),
    .dut_rdy_oe(rd_oe), .dut_rdy(rd_out), .exec_line(ex_ln), .trig_line(tg_ln),
    .ready_line(rd_ln));
  always @(posedge core_clk) begin
    n_run += run_cmd.run_pulse; n_tr += run_cmd.trace_start; n_oe += ex_oe;
    n_a += drv_a; n_b += drv_b; n_out += tg_oe;
    if (run_cmd.run_pulse) got_addr = run_cmd.run_addr;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ev(input int r, t, a, b, o, x);
    chk(n_run, r); chk(n_tr, t); chk(n_a, a); chk(n_b, b); chk(n_out, o); chk(n_oe, x);
    {n_run, n_tr, n_a, n_b, n_out, n_oe} = '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic fire(input bit trig);
    @(posedge core_clk);
    if (trig) fire_trig <= 1'b1; else fire_exec <= 1'b1;
    @(posedge core_clk);
    fire_trig <= 1'b0; fire_exec <= 1'b0;
    settle(12);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(route_addr, 32'h0000_0010);
    rd(4'h8, 32'h0000_0000); rd(ctrl_addr, 32'h0000_0000);
    fire(0); ev(0, 0, 0, 0, 0, 0); chk(rd_oe, 0);
    wr(start_addr_lo, 32'h0000_5678); wr(start_addr_hi, 32'h0000_1234);
    rd(ctrl_addr, 32'h0000_0001); chk(rd_oe, 1);
    fire(0); ev(1, 0, 0, 0, 0, 0); chk(got_addr, 32'h1234_5678);
    wr(ctrl_addr, 32'h0000_0003); wr(command_addr, 32'h0000_0001);
    settle(12); ev(1, 1, 0, 0, 0, 8);
    chk(ex_out, 32'h0000_0000); chk(tg_out, 32'h0000_0001);
    @(posedge core_clk); in_monitor <= 1'b1; settle(3); chk(rd_ln, 0);
    @(posedge core_clk); in_monitor <= 1'b0; settle(3); chk(rd_ln, 1);
    wr(command_addr, 32'h0000_0004); settle(2); chk(rd_oe, 0);
    for (int i = 0; i < 4; i++) begin
      wr(route_addr, 32'h0000_0010 | i); fire(1); ev(0, 0, i & 1, i >> 1, 0, 0);
    end
    wr(route_addr, 32'h0000_0014); trig_a <= 1'b1; settle(12); ev(0, 0, 0, 0, 1, 0);
    @(posedge core_clk); trig_a <= 1'b0;
    wr(route_addr, 32'h0000_001C); trig_a <= 1'b1; settle(12);
    ev(0, 0, 0, 0, 0, 0);
    @(posedge core_clk); trig_b <= 1'b1; settle(12); ev(0, 0, 0, 0, 1, 0);
    @(posedge core_clk); {trig_a, trig_b} <= 2'b00;
    wr(route_addr, 32'h0000_000C); trig_b <= 1'b1; settle(12);
    ev(0, 0, 0, 0, 1, 0);
    @(posedge core_clk); trig_b <= 1'b0;
    rd(irq_stat_addr, 32'h0000_0007);
    wr(irq_stat_addr, 32'h0000_0007); wr(irq_mask_addr, 32'h0000_0002); settle(2); chk(irq, 0);
    fire(1); chk(irq, 1); rd(irq_stat_addr, 32'h0000_0002);
    wr(irq_mask_addr, 32'h0000_0000); settle(2); chk(irq, 0);
    wr(irq_mask_addr, 32'h0000_0002); wr(irq_stat_addr, 32'h0000_0002); settle(2); chk(irq, 0);
    wr(command_addr, 32'h0000_0002); rd(ctrl_addr, 32'h0000_0003);
    rd(status_addr, 32'h0000_000A);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
